/* src/tfr_frame_readout.sv */
// 8x8 time-of-flight imager frame conversion and pixel-pair byte readout
//
// Overview of operation
// - Four phase samples per trigger use first select 0x34, second select 0x3D, modulation 0x30.
// - Two samples use 0x32/0x33 with modulation 0x10; one-sample rolling uses modulation 0x00, readout mode 0x23.
// - One exposure pulse serves all pixels of a frame, so one integration time applies.
// - A frame is 64 pixels of 12 bits, moved out in exactly 96 byte reads.
// - The frame is three byte reads per pair, four pairs per row, eight rows.
// - Readout starts at the vertical centre and sends two adjacent pixels as one packed pair.
// - A pair goes MSB first: even[11:4], even[3:0] with odd[3:0], odd[11:4].
// - Rows go 3,4,2,5,1,6,0,7 and within a row the pairs go columns 0&1 to 6&7.
// - Embedded format replaces a pixel with 0x7FF saturation, 0x7FE overflow, 0x800 underflow.
// - Saturation, overflow and underflow flag bits read from 0x0D/0E, 0x10/11, 0x12/13 of page 2.
// - Embedded format is on after reset and bit 6 of the readout mode register turns it off.
// - A pixel is the difference of its two storage gates as signed 12 bits plus a saturation bit.
// - Conversion handles an upper and a lower row together, starting at the centre.
`timescale 1ns/1ps
`include "tfr_regs.svh"
module tfr_frame_readout
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Register port
  input  wire logic [2:0]       reg_page,
  input  wire logic [7:0]       reg_addr,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  input  wire logic [7:0]       reg_wdata,
  output logic      [7:0]       reg_rdata_r,
  output logic                  reg_rvalid_r,
  // Trigger pin
  input  wire logic             exposure_trigger,
  // Pixel front end
  output logic                  expose_r,
  output logic      [7:0]       afe_first_sel_r,
  output logic      [7:0]       afe_second_sel_r,
  output logic      [2:0]       phase_samples_r,
  output logic                  afe_req_r,
  output logic      [1:0]       afe_rowpair_r,
  output logic      [2:0]       afe_col_r,
  input  wire logic             afe_ack,
  input  wire logic [1:0][11:0] storage_gate_first,
  input  wire logic [1:0][11:0] storage_gate_second,
  input  wire logic [1:0]       afe_sat,
  // Status
  output logic                  frame_ready_r
);

  // Register file
  logic [7:0]  first_sel_r;
  logic [7:0]  second_sel_r;
  logic [7:0]  mod_sel_r;
  logic [7:0]  rdmode_r;
  logic [15:0] sat_flags_r;
  logic [15:0] ovf_flags_r;
  logic [15:0] unf_flags_r;
  logic [15:0] sat_work_r;
  logic [15:0] ovf_work_r;
  logic [15:0] unf_work_r;

  // Control
  tfr_pkg::tfr_state_t state_r;
  tfr_pkg::tfr_state_t state_nxt;
  logic [2:0]  trig_sync_r;
  logic [4:0]  feed_pair_r;
  logic [1:0]  feed_byte_r;
  logic        feed_done_r;

  tfr_pkg::tfr_pixel_t frame_mem [`TFR_PIXELS];

  tfr_stream_if #(.W(8)) strm ();

  tfr_fifo #(.W(8), .D(`TFR_FIFO_DEPTH)) u_fifo
  (
    .clk   (clk),
    .rst_n (rst_n),
    .s     (strm.fifo)
  );

  // ------------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------------

  function automatic logic sel(input logic [2:0] page, input logic [7:0] addr,
                               input logic [2:0] p, input logic [7:0] a);
    sel = (page == p) && (addr == a);
  endfunction

  // Centre-out row of a row read
  function automatic logic [2:0] row_of(input logic [2:0] rr);
    row_of = rr[0] ? (`TFR_CENTRE_LOWER + {1'b0, rr[2:1]})
                   : (`TFR_CENTRE_UPPER - {1'b0, rr[2:1]});
  endfunction

  // Gate difference to pixel word and validity flags
  function automatic tfr_pkg::tfr_conv_t convert(input logic [11:0] ga, input logic [11:0] gb,
                                                 input logic sat, input logic raw);
    logic signed [12:0] diff;
    tfr_pkg::tfr_conv_t c;
    diff  = $signed({1'b0, ga}) - $signed({1'b0, gb});
    c.sat = sat;
    c.ovf = diff > $signed(`TFR_DIFF_MAX);
    c.unf = diff < $signed(`TFR_DIFF_MIN);
    if (!raw && c.sat)
      c.word = `TFR_CODE_SAT;
    else if (!raw && c.ovf)
      c.word = `TFR_CODE_OVF;
    else if (!raw && c.unf)
      c.word = `TFR_CODE_UNF;
    else if (diff > $signed(`TFR_CLAMP_MAX))
      c.word = `TFR_CODE_SAT;
    else if (diff < $signed(`TFR_CLAMP_MIN))
      c.word = `TFR_CODE_UNF;
    else
      c.word = diff[11:0];
    convert = c;
  endfunction

  // Phase samples per trigger from the mode registers
  function automatic logic [2:0] samples_of(input logic [7:0] mods, input logic [7:0] rdm);
    if (mods == `TFR_MOD_SEL_4)
      samples_of = 3'h4;
    else if (mods == `TFR_MOD_SEL_2)
      samples_of = 3'h2;
    else if (mods == `TFR_MOD_SEL_1 && rdm[5:0] == `TFR_RDMODE_ROLL)
      samples_of = 3'h1;
    else
      samples_of = 3'h0;
  endfunction

  // ------------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------------

  wire trig_rise  = trig_sync_r[1] && !trig_sync_r[2];
  wire raw_mode   = rdmode_r[`TFR_RAW_BIT];
  wire data_rd    = reg_rd && sel(reg_page, reg_addr, `TFR_PAGE_DATA, `TFR_OFS_DATA_PORT);
  wire conv_ack   = (state_r == tfr_pkg::ST_CONVERT) && afe_req_r && afe_ack;
  wire conv_last  = conv_ack && afe_rowpair_r == `TFR_LAST_ROWPAIR && afe_col_r == `TFR_LAST_COL;
  wire [2:0] up_row  = `TFR_CENTRE_UPPER - {1'b0, afe_rowpair_r};
  wire [2:0] low_row = `TFR_CENTRE_LOWER + {1'b0, afe_rowpair_r};
  wire [3:0] up_grp  = {up_row[2:1], afe_col_r[2:1]};
  wire [3:0] low_grp = {low_row[2:1], afe_col_r[2:1]};
  wire tfr_pkg::tfr_conv_t up_conv = convert(storage_gate_first[0], storage_gate_second[0],
                                             afe_sat[0], raw_mode);
  wire tfr_pkg::tfr_conv_t low_conv = convert(storage_gate_first[1], storage_gate_second[1],
                                              afe_sat[1], raw_mode);
  wire [15:0] up_bit  = 16'h0001 << up_grp;
  wire [15:0] low_bit = 16'h0001 << low_grp;

  // Byte source: pair index -> row read and column pair
  wire [2:0] rd_row    = row_of(feed_pair_r[4:2]);
  wire [5:0] even_addr = {rd_row, feed_pair_r[1:0], 1'b0};
  wire [5:0] odd_addr  = {rd_row, feed_pair_r[1:0], 1'b1};
  wire tfr_pkg::tfr_pixel_t even_pix = frame_mem[even_addr];
  wire tfr_pkg::tfr_pixel_t odd_pix  = frame_mem[odd_addr];
  wire [7:0] pack_byte = (feed_byte_r == 2'h0) ? even_pix[11:4] :
                         (feed_byte_r == 2'h1) ? {even_pix[3:0], odd_pix[3:0]} :
                                                 odd_pix[11:4];
  wire feed_push = (state_r == tfr_pkg::ST_READOUT) && !feed_done_r && strm.wr_ready;
  wire feed_last = feed_pair_r == `TFR_LAST_PAIR && feed_byte_r == `TFR_LAST_BYTE;

  assign strm.wr_valid = feed_push;
  assign strm.wr_data  = pack_byte;
  assign strm.rd_ready = data_rd;

  logic [7:0] rd_mux;
  always_comb
  begin
    rd_mux = 8'h00;
    if (sel(reg_page, reg_addr, `TFR_PAGE_MODE, `TFR_OFS_FIRST_SEL))
      rd_mux = first_sel_r;
    else if (sel(reg_page, reg_addr, `TFR_PAGE_MODE, `TFR_OFS_SECOND_SEL))
      rd_mux = second_sel_r;
    else if (data_rd)
      rd_mux = strm.rd_valid ? strm.rd_data : 8'h00;
    else if (sel(reg_page, reg_addr, `TFR_PAGE_DATA, `TFR_OFS_SAT_A))
      rd_mux = sat_flags_r[7:0];
    else if (sel(reg_page, reg_addr, `TFR_PAGE_DATA, `TFR_OFS_SAT_B))
      rd_mux = sat_flags_r[15:8];
    else if (sel(reg_page, reg_addr, `TFR_PAGE_DATA, `TFR_OFS_OVF_A))
      rd_mux = ovf_flags_r[7:0];
    else if (sel(reg_page, reg_addr, `TFR_PAGE_DATA, `TFR_OFS_OVF_B))
      rd_mux = ovf_flags_r[15:8];
    else if (sel(reg_page, reg_addr, `TFR_PAGE_DATA, `TFR_OFS_UNF_A))
      rd_mux = unf_flags_r[7:0];
    else if (sel(reg_page, reg_addr, `TFR_PAGE_DATA, `TFR_OFS_UNF_B))
      rd_mux = unf_flags_r[15:8];
    else if (sel(reg_page, reg_addr, `TFR_PAGE_CTRL, `TFR_OFS_MOD_SEL))
      rd_mux = mod_sel_r;
    else if (sel(reg_page, reg_addr, `TFR_PAGE_CTRL, `TFR_OFS_RDMODE))
      rd_mux = rdmode_r;
  end

  // ------------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------------

  // A trigger that rises before the host has drained the frame is ignored,
  // so the frame store is never overwritten under an unfinished readout.
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      tfr_pkg::ST_IDLE:
        if (trig_rise)
          state_nxt = tfr_pkg::ST_EXPOSE;
      tfr_pkg::ST_EXPOSE:
        state_nxt = tfr_pkg::ST_CONVERT;
      tfr_pkg::ST_CONVERT:
        if (conv_last)
          state_nxt = tfr_pkg::ST_READOUT;
      tfr_pkg::ST_READOUT:
        if (feed_done_r && !strm.rd_valid)
          state_nxt = tfr_pkg::ST_IDLE;
      default:
        state_nxt = tfr_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r     <= tfr_pkg::ST_IDLE;
      trig_sync_r <= 3'h0;
    end
    else
    begin
      state_r     <= state_nxt;
      trig_sync_r <= {trig_sync_r[1:0], exposure_trigger};
    end
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      first_sel_r  <= `TFR_RST_FIRST_SEL;
      second_sel_r <= `TFR_RST_SECOND_SEL;
      mod_sel_r    <= `TFR_RST_MOD_SEL;
      rdmode_r     <= `TFR_RST_RDMODE;
    end
    else if (reg_wr)
    begin
      if (sel(reg_page, reg_addr, `TFR_PAGE_MODE, `TFR_OFS_FIRST_SEL))
        first_sel_r <= reg_wdata;
      if (sel(reg_page, reg_addr, `TFR_PAGE_MODE, `TFR_OFS_SECOND_SEL))
        second_sel_r <= reg_wdata;
      if (sel(reg_page, reg_addr, `TFR_PAGE_CTRL, `TFR_OFS_MOD_SEL))
        mod_sel_r <= reg_wdata;
      if (sel(reg_page, reg_addr, `TFR_PAGE_CTRL, `TFR_OFS_RDMODE))
        rdmode_r <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata_r  <= 8'h00;
      reg_rvalid_r <= 1'b0;
    end
    else
    begin
      reg_rdata_r  <= reg_rd ? rd_mux : reg_rdata_r;
      reg_rvalid_r <= reg_rd;
    end
  end

  // ------------------------------------------------------------------
  // Conversion
  // ------------------------------------------------------------------

  always_ff @(posedge clk)
  begin
    if (conv_ack)
    begin
      frame_mem[{up_row, afe_col_r}]  <= up_conv.word;
      frame_mem[{low_row, afe_col_r}] <= low_conv.word;
    end
  end

  // Flags build in a work copy and are published at frame end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sat_work_r  <= 16'h0000;
      ovf_work_r  <= 16'h0000;
      unf_work_r  <= 16'h0000;
      sat_flags_r <= 16'h0000;
      ovf_flags_r <= 16'h0000;
      unf_flags_r <= 16'h0000;
    end
    else if (state_r == tfr_pkg::ST_EXPOSE)
    begin
      sat_work_r <= 16'h0000;
      ovf_work_r <= 16'h0000;
      unf_work_r <= 16'h0000;
    end
    else if (conv_ack)
    begin
      sat_work_r <= sat_work_r | (up_conv.sat ? up_bit : 16'h0000) | (low_conv.sat ? low_bit : 16'h0000);
      ovf_work_r <= ovf_work_r | (up_conv.ovf ? up_bit : 16'h0000) | (low_conv.ovf ? low_bit : 16'h0000);
      unf_work_r <= unf_work_r | (up_conv.unf ? up_bit : 16'h0000) | (low_conv.unf ? low_bit : 16'h0000);
      if (conv_last)
      begin
        sat_flags_r <= sat_work_r | (up_conv.sat ? up_bit : 16'h0000) | (low_conv.sat ? low_bit : 16'h0000);
        ovf_flags_r <= ovf_work_r | (up_conv.ovf ? up_bit : 16'h0000) | (low_conv.ovf ? low_bit : 16'h0000);
        unf_flags_r <= unf_work_r | (up_conv.unf ? up_bit : 16'h0000) | (low_conv.unf ? low_bit : 16'h0000);
      end
    end
  end

  // Front end outputs
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      expose_r         <= 1'b0;
      afe_first_sel_r  <= 8'h00;
      afe_second_sel_r <= 8'h00;
      phase_samples_r  <= 3'h0;
      afe_req_r        <= 1'b0;
      afe_rowpair_r    <= 2'h0;
      afe_col_r        <= 3'h0;
    end
    else
    begin
      expose_r        <= (state_nxt == tfr_pkg::ST_EXPOSE) && (state_r != tfr_pkg::ST_EXPOSE);
      phase_samples_r <= samples_of(mod_sel_r, rdmode_r);
      afe_first_sel_r <= first_sel_r;
      afe_second_sel_r <= (samples_of(mod_sel_r, rdmode_r) == 3'h1) ? 8'h00 : second_sel_r;
      if (state_r == tfr_pkg::ST_EXPOSE)
      begin
        afe_req_r     <= 1'b1;
        afe_rowpair_r <= 2'h0;
        afe_col_r     <= 3'h0;
      end
      else if (conv_ack)
      begin
        afe_req_r     <= !conv_last;
        afe_col_r     <= afe_col_r + 3'h1;
        afe_rowpair_r <= (afe_col_r == `TFR_LAST_COL) ? afe_rowpair_r + 2'h1 : afe_rowpair_r;
      end
    end
  end

  // ------------------------------------------------------------------
  // Byte feeder
  // ------------------------------------------------------------------

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      feed_pair_r   <= 5'h00;
      feed_byte_r   <= 2'h0;
      feed_done_r   <= 1'b0;
      frame_ready_r <= 1'b0;
    end
    else
    begin
      frame_ready_r <= (state_nxt == tfr_pkg::ST_READOUT);
      if (state_r == tfr_pkg::ST_EXPOSE)
      begin
        feed_pair_r <= 5'h00;
        feed_byte_r <= 2'h0;
        feed_done_r <= 1'b0;
      end
      else if (feed_push)
      begin
        feed_done_r <= feed_last;
        feed_byte_r <= (feed_byte_r == `TFR_LAST_BYTE) ? 2'h0 : feed_byte_r + 2'h1;
        if (feed_byte_r == `TFR_LAST_BYTE)
          feed_pair_r <= feed_pair_r + 5'h01;
      end
    end
  end

endmodule

/* include/tfr_regs.svh */
// Register offsets, field positions, reset values and counts of the imager readout
`ifndef TFR_REGS_SVH
`define TFR_REGS_SVH

// Pages
`define TFR_PAGE_MODE      3'h1
`define TFR_PAGE_DATA      3'h2
`define TFR_PAGE_CTRL      3'h4

// Offsets
`define TFR_OFS_FIRST_SEL  8'h02
`define TFR_OFS_SECOND_SEL 8'h05
`define TFR_OFS_DATA_PORT  8'h0C
`define TFR_OFS_SAT_A      8'h0D
`define TFR_OFS_SAT_B      8'h0E
`define TFR_OFS_OVF_A      8'h10
`define TFR_OFS_OVF_B      8'h11
`define TFR_OFS_UNF_A      8'h12
`define TFR_OFS_UNF_B      8'h13
`define TFR_OFS_MOD_SEL    8'h12
`define TFR_OFS_RDMODE     8'h15

// Mode selection values
`define TFR_FIRST_SEL_4    8'h34
`define TFR_SECOND_SEL_4   8'h3D
`define TFR_MOD_SEL_4      8'h30
`define TFR_FIRST_SEL_2B   8'h32
`define TFR_SECOND_SEL_2B  8'h33
`define TFR_MOD_SEL_2      8'h10
`define TFR_MOD_SEL_1      8'h00
`define TFR_RDMODE_ROLL    6'h23
`define TFR_RAW_BIT        6

// Reset values
`define TFR_RST_FIRST_SEL  8'h34
`define TFR_RST_SECOND_SEL 8'h3D
`define TFR_RST_MOD_SEL    8'h30
`define TFR_RST_RDMODE     8'h00

// Embedded validity codes and valid range of the signed difference
`define TFR_CODE_SAT       12'h7FF
`define TFR_CODE_OVF       12'h7FE
`define TFR_CODE_UNF       12'h800
`define TFR_DIFF_MAX       13'h07FD
`define TFR_DIFF_MIN       13'h1801
`define TFR_CLAMP_MAX      13'h07FF
`define TFR_CLAMP_MIN      13'h1800

// Frame geometry and counts
`define TFR_LAST_BYTE      2'h2
`define TFR_LAST_PAIR      5'h1F
`define TFR_LAST_COL       3'h7
`define TFR_LAST_ROWPAIR   2'h3
`define TFR_CENTRE_UPPER   3'h3
`define TFR_CENTRE_LOWER   3'h4
`define TFR_PIXELS         64
`define TFR_FIFO_DEPTH     8

`endif

/* include/tfr_pkg.sv */
// Types shared by the imager readout modules
package tfr_pkg;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0001,
    ST_EXPOSE  = 4'b0010,
    ST_CONVERT = 4'b0100,
    ST_READOUT = 4'b1000
  } tfr_state_t;

  typedef logic [11:0] tfr_pixel_t;

  typedef struct packed {
    logic       sat;
    logic       ovf;
    logic       unf;
    tfr_pixel_t word;
  } tfr_conv_t;

endpackage

/* include/tfr_stream_if.sv */
// Byte stream between the frame feeder and the data port FIFO
`timescale 1ns/1ps
interface tfr_stream_if #(parameter int W = 8);
  logic         wr_valid;
  logic         wr_ready;
  logic [W-1:0] wr_data;
  logic         rd_valid;
  logic         rd_ready;
  logic [W-1:0] rd_data;

  modport fifo
  (
    input  wr_valid,
    output wr_ready,
    input  wr_data,
    output rd_valid,
    input  rd_ready,
    output rd_data
  );

  modport user
  (
    output wr_valid,
    input  wr_ready,
    output wr_data,
    input  rd_valid,
    output rd_ready,
    input  rd_data
  );
endinterface

/* src/tfr_fifo.sv */
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module tfr_fifo
#(
  parameter int W = 8,
  parameter int D = 8
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Stream
  tfr_stream_if.fifo s
);

  localparam int AW = $clog2(D);

  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0]   cnt_r;

  wire push = s.wr_valid && s.wr_ready;
  wire pop  = s.rd_valid && s.rd_ready;

  assign s.wr_ready = (cnt_r != (AW+1)'(D));
  assign s.rd_valid = (cnt_r != '0);
  assign s.rd_data  = mem[rp_r];

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wp_r] <= s.wr_data;
  end

  // Pointers wrap by compare so non power-of-two depths still work
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end
    else
    begin
      if (push)
        wp_r <= (wp_r == AW'(D-1)) ? '0 : wp_r + AW'(1);
      if (pop)
        rp_r <= (rp_r == AW'(D-1)) ? '0 : rp_r + AW'(1);
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule

/* sim/tfr_afe_model.sv */
// Pixel front end stand-in answering conversion requests with gate charges
`timescale 1ns/1ps
module tfr_afe_model
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Answer pace
  input  wire logic             slow,
  // Request side
  input  wire logic             afe_req_r,
  input  wire logic [1:0]       afe_rowpair_r,
  input  wire logic [2:0]       afe_col_r,
  output logic                  afe_ack,
  output logic      [1:0][11:0] g_first,
  output logic      [1:0][11:0] g_second,
  output logic      [1:0]       afe_sat
);
  logic [2:0]       cnt_r;
  logic [1:0][11:0] f_nxt;
  logic [1:0][11:0] s_nxt;
  wire  unf = afe_rowpair_r == 2'h3 && afe_col_r == 3'h1;
  wire  ovf = afe_rowpair_r == 2'h3 && afe_col_r == 3'h0;
  wire  hit = afe_req_r && !afe_ack && cnt_r >= (slow ? 3'h5 : 3'h0);
  // Index 0 is upper row 3-p, index 1 lower row 4+p
  assign f_nxt[0] = unf ? 12'h000 : 12'h400 + {6'h00, afe_rowpair_r, 1'b0, afe_col_r};
  assign s_nxt[0] = unf ? 12'hFFF : 12'h200;
  assign f_nxt[1] = ovf ? 12'hFFF : 12'h200;
  assign s_nxt[1] = ovf ? 12'h000 : 12'h300 + {9'h000, afe_col_r};
  // Between answers the gate lines toggle, so stale data never looks valid
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      afe_ack  <= 1'b0;
      cnt_r    <= 3'h0;
      g_first  <= '0;
      g_second <= '0;
      afe_sat  <= 2'h0;
    end
    else
    begin
      afe_ack  <= hit;
      cnt_r    <= (hit || !afe_req_r) ? 3'h0 : cnt_r + 3'h1;
      g_first  <= hit ? f_nxt : ~g_first;
      g_second <= hit ? s_nxt : ~g_second;
      afe_sat  <= hit ? {1'b0, afe_rowpair_r == 2'h0 && afe_col_r == 3'h7} : ~afe_sat;
    end
endmodule

/* sim/tfr_frame_readout_sva.sv */
// Concurrent checks on the imager readout top-level ports
`timescale 1ns/1ps
module tfr_frame_readout_sva
(
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // Register port
  input wire logic [2:0] reg_page,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_rvalid_r,
  // Front end and status
  input wire logic       expose_r,
  input wire logic       afe_req_r,
  input wire logic [1:0] afe_rowpair_r,
  input wire logic [2:0] afe_col_r,
  input wire logic       afe_ack,
  input wire logic [2:0] phase_samples_r,
  input wire logic       frame_ready_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire take = afe_req_r && afe_ack;
  wire last = take && afe_col_r == 3'h7 && afe_rowpair_r == 2'h3;
  wire mod_wr = reg_wr && reg_page == 3'h4 && reg_addr == 8'h12;

  rd_answer_a: assert property (reg_rd |=> reg_rvalid_r)
    else $error("read without answer");
  rd_cause_a: assert property (reg_rvalid_r |-> $past(reg_rd))
    else $error("answer without read");
  expose_once_a: assert property (expose_r |=> !expose_r [*8])
    else $error("second exposure");
  expose_req_a: assert property (expose_r |=> afe_req_r && afe_rowpair_r == 2'h0 && afe_col_r == 3'h0)
    else $error("conversion start wrong");
  req_hold_a: assert property (afe_req_r && !afe_ack |=> afe_req_r && $stable(afe_col_r) && $stable(afe_rowpair_r))
    else $error("request dropped");
  col_step_a: assert property (take && afe_col_r != 3'h7 |=> afe_col_r == $past(afe_col_r) + 3'h1)
    else $error("column order wrong");
  pair_step_a: assert property (take && afe_col_r == 3'h7 && afe_rowpair_r != 2'h3 |=> afe_col_r == 3'h0 && afe_rowpair_r == $past(afe_rowpair_r) + 2'h1)
    else $error("row pair order wrong");
  last_ack_a: assert property (last |=> !afe_req_r ##[0:2] frame_ready_r)
    else $error("frame not ready");
  phase_two_a: assert property (mod_wr && reg_wdata == 8'h10 |-> ##[1:3] phase_samples_r == 3'h2)
    else $error("two sample mode");
  phase_four_a: assert property (mod_wr && reg_wdata == 8'h30 |-> ##[1:3] phase_samples_r == 3'h4)
    else $error("four sample mode");

  cover property (expose_r);
  cover property (last);
  cover property (reg_rd && reg_page == 3'h2 && reg_addr == 8'h0C);
endmodule
bind tfr_frame_readout tfr_frame_readout_sva u_sva (.clk, .rst_n, .reg_page, .reg_addr,
  .reg_wr, .reg_rd, .reg_wdata, .reg_rvalid_r, .expose_r, .afe_req_r, .afe_rowpair_r,
  .afe_col_r, .afe_ack, .phase_samples_r, .frame_ready_r);

/* sim/tfr_frame_readout_tb.sv */
// Self-checking bench for the imager frame readout
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin err_count++; \
  $display("ERROR %0t: got %h want %h", $time, a, e); end end
module tfr_frame_readout_tb;
  logic             clk, rst_n, reg_wr, reg_rd, trig, slow;
  logic [2:0]       reg_page, phase_samples_r, afe_col_r;
  logic [7:0]       reg_addr, reg_wdata, reg_rdata_r, rd_v;
  logic             reg_rvalid_r, expose_r, afe_req_r, afe_ack, frame_ready_r;
  logic [7:0]       afe_first_sel_r, afe_second_sel_r;
  logic [1:0]       afe_rowpair_r, afe_sat;
  logic [1:0][11:0] g_first, g_second;
  int               err_count, checks_done, n_exp, frames;
  int               row_ord [8] = '{3, 4, 2, 5, 1, 6, 0, 7};
  // Page, offset, expected value after reset
  logic [18:0]      rst_tab [6] = '{{3'h1, 8'h02, 8'h34}, {3'h1, 8'h05, 8'h3D},
    {3'h4, 8'h12, 8'h30}, {3'h4, 8'h15, 8'h00}, {3'h2, 8'h0C, 8'h00}, {3'h3, 8'h00, 8'h00}};
  // Flag offset, expected flags of the test frame
  logic [15:0]      flag_tab [6] = '{{8'h0D, 8'h80}, {8'h0E, 8'h00}, {8'h10, 8'h00},
    {8'h11, 8'h10}, {8'h12, 8'h01}, {8'h13, 8'h00}};

  tfr_frame_readout u_dut (.clk(clk), .rst_n(rst_n), .reg_page(reg_page),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata_r(reg_rdata_r), .reg_rvalid_r(reg_rvalid_r), .exposure_trigger(trig),
    .expose_r(expose_r), .afe_first_sel_r(afe_first_sel_r),
    .afe_second_sel_r(afe_second_sel_r), .phase_samples_r(phase_samples_r),
    .afe_req_r(afe_req_r), .afe_rowpair_r(afe_rowpair_r), .afe_col_r(afe_col_r),
    .afe_ack(afe_ack), .storage_gate_first(g_first), .storage_gate_second(g_second),
    .afe_sat(afe_sat), .frame_ready_r(frame_ready_r));
  tfr_afe_model u_afe (.clk(clk), .rst_n(rst_n), .slow(slow), .afe_req_r(afe_req_r),
    .afe_rowpair_r(afe_rowpair_r), .afe_col_r(afe_col_r), .afe_ack(afe_ack),
    .g_first(g_first), .g_second(g_second), .afe_sat(afe_sat));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Counted mid-cycle, away from the edge that launches the pulse
  always @(negedge clk)
    if (expose_r === 1'b1)
      n_exp++;

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic summarize();
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic wait_for(ref logic s, input logic v, input int lim);
    for (int n = 0; n < lim && s !== v; n++)
      @(negedge clk);
    if (s !== v)
    begin
      err_count++;
      summarize();
    end
  endtask

  task automatic wr(input logic [2:0] p, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_page  <= p;
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  // Ends on a rising edge so callers may drive straight after
  task automatic rd(input logic [2:0] p, input logic [7:0] a);
    @(posedge clk);
    reg_page <= p;
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    wait_for(reg_rvalid_r, 1'b1, 3);
    rd_v = reg_rdata_r;
    repeat (3) @(posedge clk);
  endtask

  // Expected word at a physical position
  function automatic logic [11:0] pix(int row, int col, logic raw);
    int p;
    p = row < 4 ? 3 - row : row - 4;
    if (row == 3 && col == 7 && !raw)
      return 12'h7FF;
    if (row == 7 && col == 0)
      return raw ? 12'h7FF : 12'h7FE;
    if (row == 0 && col == 1)
      return 12'h800;
    if (row < 4)
      return 12'h200 + 12'(p * 16 + col);
    return 12'hF00 - 12'(col);
  endfunction

  task automatic frame(input logic raw);
    logic [11:0] e, o;
    @(posedge clk);
    trig <= 1'b1;
    wait_for(expose_r, 1'b1, 10);
    frames++;
    @(posedge clk);
    trig <= 1'b0;
    rd(3'h2, 8'h0C);
    `CHK(rd_v, 8'h00)
    wait_for(frame_ready_r, 1'b1, 600);
    for (int r = 0; r < 8; r++)
      for (int k = 0; k < 4; k++)
      begin
        e = pix(row_ord[r], 2 * k, raw);
        o = pix(row_ord[r], 2 * k + 1, raw);
        rd(3'h2, 8'h0C);
        `CHK(rd_v, e[11:4])
        rd(3'h2, 8'h0C);
        `CHK(rd_v, {e[3:0], o[3:0]})
        rd(3'h2, 8'h0C);
        `CHK(rd_v, o[11:4])
        if (r == 2)
          trig <= (k == 0);
      end
    wait_for(frame_ready_r, 1'b0, 20);
    rd(3'h2, 8'h0C);
    `CHK(rd_v, 8'h00)
    `CHK(n_exp, frames)
    foreach (flag_tab[i])
    begin
      rd(3'h2, flag_tab[i][15:8]);
      `CHK(rd_v, flag_tab[i][7:0])
    end
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    rst_n     = 1'b0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_page  = 3'h0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    trig      = 1'b0;
    slow      = 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rst_tab[i])
    begin
      rd(rst_tab[i][18:16], rst_tab[i][15:8]);
      `CHK(rd_v, rst_tab[i][7:0])
    end
    `CHK(phase_samples_r, 3'h4)
    `CHK({afe_first_sel_r, afe_second_sel_r}, 16'h343D)
    frame(1'b0);
    wr(3'h4, 8'h12, 8'h10);
    wr(3'h1, 8'h02, 8'h32);
    wr(3'h1, 8'h05, 8'h33);
    repeat (2) @(posedge clk);
    `CHK(phase_samples_r, 3'h2)
    `CHK({afe_first_sel_r, afe_second_sel_r}, 16'h3233)
    wr(3'h4, 8'h15, 8'h23);
    wr(3'h4, 8'h12, 8'h00);
    repeat (2) @(posedge clk);
    `CHK(phase_samples_r, 3'h1)
    `CHK(afe_second_sel_r, 8'h00)
    wr(3'h4, 8'h12, 8'h30);
    wr(3'h1, 8'h02, 8'h34);
    wr(3'h1, 8'h05, 8'h3D);
    wr(3'h4, 8'h15, 8'h40);
    rd(3'h4, 8'h15);
    `CHK(rd_v, 8'h40)
    slow <= 1'b1;
    frame(1'b1);
    summarize();
  end
endmodule
